//--- include/scrc_map.svh
`ifndef SCRC_MAP_SVH
`define SCRC_MAP_SVH

// ========================================
// register byte offsets
`define SCRC_OFS_STATUS 8'h00
`define SCRC_OFS_PLAT   8'h04
`define SCRC_OFS_CORE0  8'h08
`define SCRC_OFS_CORE1  8'h0C
`define SCRC_OFS_MEM    8'h10
`define SCRC_OFS_CTRL   8'h14

// ========================================
// field positions
`define SCRC_ST_LOCKED  0
`define SCRC_ST_SYNC    1
`define SCRC_ST_PRSV    2
`define SCRC_ST_CRSV    3
`define SCRC_MULT_LSB   8
`define SCRC_MEM_REFSEL 8
`define SCRC_CTRL_MCKEN 0

// ========================================
// reset values and codes
`define SCRC_CTRL_RST   1'h1
`define SCRC_MEM_SYNC   3'h7
`define SCRC_RESP_OKAY  2'h0
`define SCRC_RESP_SLV   2'h2

// ========================================
// timing: strap settle time after reset release
`define SCRC_CLK_NS     40
`define SCRC_SETTLE_NS  200
`define SCRC_SETTLE_CYC ((`SCRC_SETTLE_NS + `SCRC_CLK_NS - 1) / `SCRC_CLK_NS)

`endif

//--- include/scrc_pkg.sv
`default_nettype none
// ========================================
// types shared by the clock ratio block
package scrc_pkg;
    // strap capture sequence
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_SAMPLE,
        ST_LOCKED
    } scrc_state_t;
endpackage
`default_nettype wire

//--- hdl/scrc_top.sv
// ========================================
// Overview of operation
// - platform clock equals reference times strap ratio
// - platform codes 4,5,6,8,10,12; 110/111 reserved
// - core0 ratio 3:2..7:2; codes 000-010 reserved
// - each core ratio from its own straps
// - synchronous memory clock is half platform clock
// - asynchronous memory PLL uses memory reference clock
// - memory clock outputs run at half data rate
// - memory strap 111 selects synchronous mode
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "scrc_map.svh"
`default_nettype none

module scrc_top #(
    parameter int SETTLE_CYC = `SCRC_SETTLE_CYC,
    parameter int NUM_MCK    = 6
) (
    // clock and reset
    input  wire logic               REF_CLK,
    input  wire logic               RSTN,
    // straps from the board
    input  wire logic [2:0]         PLATFORM_RATIO_STRAPS,
    input  wire logic               CORE0_RATIO_STRAP_MSB,
    input  wire logic               CORE0_RATIO_STRAP_MID,
    input  wire logic               CORE0_RATIO_STRAP_LSB,
    input  wire logic [2:0]         CORE1_RATIO_STRAPS,
    input  wire logic [2:0]         MEM_PLL_CFG_STRAPS,
    // pll controls
    output logic [3:0]              PLAT_PLL_MULT,
    output logic                    PLAT_PLL_EN,
    output logic [2:0]              CORE0_PLL_HALF_MULT,
    output logic                    CORE0_PLL_EN,
    output logic [2:0]              CORE1_RATIO_CODE,
    output logic                    MEM_PLL_EN,
    output logic                    MEM_PLL_REF_SEL,
    output logic                    MEM_CLK_DIV2_SEL,
    output logic                    CFG_LOCKED,
    // memory clock outputs
    output logic [NUM_MCK-1:0]      MEM_CLK_P,
    output logic [NUM_MCK-1:0]      MEM_CLK_N,
    // axi4-lite slave
    input  wire logic [7:0]         S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output logic                    S_AXI_AWREADY,
    input  wire logic [31:0]        S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output logic                    S_AXI_WREADY,
    output logic [1:0]              S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    input  wire logic [7:0]         S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output logic                    S_AXI_ARREADY,
    output logic [31:0]             S_AXI_RDATA,
    output logic [1:0]              S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY
);

    // ========================================
    // decode functions
    // platform multiplier, zero for reserved codes
    function automatic logic [3:0] plat_mult(input logic [2:0] code);
        unique case (code)
            3'h0:    plat_mult = 4'h4;
            3'h1:    plat_mult = 4'h5;
            3'h2:    plat_mult = 4'h6;
            3'h3:    plat_mult = 4'h8;
            3'h4:    plat_mult = 4'hA;
            3'h5:    plat_mult = 4'hC;
            default: plat_mult = 4'h0;
        endcase
    endfunction

    // core0 ratio in halves, zero for reserved codes
    function automatic logic [2:0] core0_half(input logic [2:0] code);
        core0_half = (code >= 3'h3) ? code : 3'h0;
    endfunction

    // address is one of the six registers
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a[1:0] == 2'h0) && (a <= `SCRC_OFS_CTRL);
    endfunction

    // ========================================
    // strap synchronisers, three stages
    logic [11:0] strap_pins;            // all straps gathered
    logic [11:0] sync1_ff;              // first stage, read only by second
    logic [11:0] sync2_ff;              // second stage
    logic [11:0] sync3_ff;              // third stage

    assign strap_pins = {MEM_PLL_CFG_STRAPS, CORE1_RATIO_STRAPS,
                         CORE0_RATIO_STRAP_MSB, CORE0_RATIO_STRAP_MID,
                         CORE0_RATIO_STRAP_LSB, PLATFORM_RATIO_STRAPS};

    // shift register, constant under reset
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sync1_ff <= 12'h000;
            sync2_ff <= 12'h000;
            sync3_ff <= 12'h000;
        end
        else
        begin
            sync1_ff <= strap_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // ========================================
    // strap capture and ratio decode
    scrc_pkg::scrc_state_t state_ff;        // capture sequence
    scrc_pkg::scrc_state_t nxt_state;
    logic [7:0]  settle_cnt_ff;             // settle counter
    logic [7:0]  nxt_settle_cnt;
    logic [11:0] strap_ff;                  // latched strap codes
    logic [11:0] nxt_strap;
    logic [3:0]  plat_mult_ff;
    logic [3:0]  nxt_plat_mult;
    logic        plat_en_ff;
    logic        nxt_plat_en;
    logic [2:0]  core0_half_ff;
    logic [2:0]  nxt_core0_half;
    logic        core0_en_ff;
    logic        nxt_core0_en;
    logic        mem_sync_ff;               // synchronous memory mode
    logic        nxt_mem_sync;
    logic        locked_ff;
    logic        nxt_locked;

    // wait the settle time, latch once the last stages agree
    always_comb
    begin
        nxt_state      = state_ff;
        nxt_settle_cnt = settle_cnt_ff;
        nxt_strap      = strap_ff;
        nxt_locked     = locked_ff;
        unique case (state_ff)
            scrc_pkg::ST_SETTLE:
            begin
                if (settle_cnt_ff >= 8'(SETTLE_CYC - 1))
                    nxt_state = scrc_pkg::ST_SAMPLE;
                else
                    nxt_settle_cnt = settle_cnt_ff + 8'h01;
            end
            scrc_pkg::ST_SAMPLE:
            begin
                // latch only a settled value
                if (sync2_ff == sync3_ff)
                begin
                    nxt_strap  = sync3_ff;
                    nxt_locked = 1'b1;
                    nxt_state  = scrc_pkg::ST_LOCKED;
                end
            end
            scrc_pkg::ST_LOCKED:
            begin
                // later pin changes are ignored
                nxt_state = scrc_pkg::ST_LOCKED;
            end
        endcase
        // platform multiplier from its own field
        nxt_plat_mult  = nxt_locked ? plat_mult(nxt_strap[2:0]) : 4'h0;
        nxt_plat_en    = nxt_locked && (nxt_plat_mult != 4'h0);
        // core0 ratio from its own straps
        nxt_core0_half = nxt_locked ? core0_half(nxt_strap[5:3]) : 3'h0;
        nxt_core0_en   = nxt_locked && (nxt_core0_half != 3'h0);
        // memory strap 111 means synchronous
        nxt_mem_sync   = nxt_strap[11:9] == `SCRC_MEM_SYNC;
    end

    // capture registers
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_ff      <= scrc_pkg::ST_SETTLE;
            settle_cnt_ff <= 8'h00;
            strap_ff      <= 12'h000;
            plat_mult_ff  <= 4'h0;
            plat_en_ff    <= 1'b0;
            core0_half_ff <= 3'h0;
            core0_en_ff   <= 1'b0;
            mem_sync_ff   <= 1'b0;
            locked_ff     <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            settle_cnt_ff <= nxt_settle_cnt;
            strap_ff      <= nxt_strap;
            plat_mult_ff  <= nxt_plat_mult;
            plat_en_ff    <= nxt_plat_en;
            core0_half_ff <= nxt_core0_half;
            core0_en_ff   <= nxt_core0_en;
            mem_sync_ff   <= nxt_mem_sync;
            locked_ff     <= nxt_locked;
        end
    end

    assign PLAT_PLL_MULT       = plat_mult_ff;
    assign PLAT_PLL_EN         = plat_en_ff;
    assign CORE0_PLL_HALF_MULT = core0_half_ff;
    assign CORE0_PLL_EN        = core0_en_ff;
    assign CORE1_RATIO_CODE    = strap_ff[8:6];
    assign CFG_LOCKED          = locked_ff;
    // sync: platform divided by two; async: own pll
    assign MEM_CLK_DIV2_SEL    = mem_sync_ff;
    assign MEM_PLL_REF_SEL     = !mem_sync_ff;
    assign MEM_PLL_EN          = locked_ff && !mem_sync_ff;

    // ========================================
    // memory clock pairs, half the data-rate clock
    logic ctrl_mcken_ff;                    // software output enable
    logic mck_ff;
    logic nxt_mck;

    // toggle each data beat while running
    always_comb
    begin
        nxt_mck = (locked_ff && ctrl_mcken_ff) ? !mck_ff : 1'b0;
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
            mck_ff <= 1'b0;
        else
            mck_ff <= nxt_mck;
    end

    // one complementary pair per output
    generate
        for (genvar i = 0; i < NUM_MCK; i++)
        begin : g_mck
            always_ff @(posedge REF_CLK or negedge RSTN)
            begin
                if (!RSTN)
                begin
                    MEM_CLK_P[i] <= 1'b0;
                    MEM_CLK_N[i] <= 1'b1;
                end
                else
                begin
                    MEM_CLK_P[i] <= nxt_mck;
                    MEM_CLK_N[i] <= !nxt_mck;
                end
            end
        end
    endgenerate

    // ========================================
    // axi4-lite write channel
    logic [7:0]  awaddr_ff;
    logic [7:0]  nxt_awaddr;
    logic        aw_have_ff;
    logic        nxt_aw_have;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic        wstrb0_ff;
    logic        nxt_wstrb0;
    logic        w_have_ff;
    logic        nxt_w_have;
    logic        awready_ff;
    logic        nxt_awready;
    logic        wready_ff;
    logic        nxt_wready;
    logic        bvalid_ff;
    logic        nxt_bvalid;
    logic [1:0]  bresp_ff;
    logic [1:0]  nxt_bresp;
    logic        nxt_ctrl_mcken;

    // take address and data in any order, answer when both held
    always_comb
    begin
        nxt_awaddr     = awaddr_ff;
        nxt_wdata      = wdata_ff;
        nxt_wstrb0     = wstrb0_ff;
        nxt_bresp      = bresp_ff;
        nxt_ctrl_mcken = ctrl_mcken_ff;
        nxt_bvalid     = bvalid_ff && !S_AXI_BREADY;
        nxt_aw_have    = aw_have_ff || (S_AXI_AWVALID && awready_ff);
        nxt_w_have     = w_have_ff || (S_AXI_WVALID && wready_ff);
        if (S_AXI_AWVALID && awready_ff)
            nxt_awaddr = S_AXI_AWADDR;
        if (S_AXI_WVALID && wready_ff)
        begin
            nxt_wdata  = S_AXI_WDATA;
            nxt_wstrb0 = S_AXI_WSTRB[0];
        end
        if (nxt_aw_have && nxt_w_have && !bvalid_ff)
        begin
            // only the control register is writable
            if (nxt_awaddr == `SCRC_OFS_CTRL && nxt_wstrb0)
                nxt_ctrl_mcken = nxt_wdata[`SCRC_CTRL_MCKEN];
            nxt_bresp   = addr_mapped(nxt_awaddr) ? `SCRC_RESP_OKAY : `SCRC_RESP_SLV;
            nxt_bvalid  = 1'b1;
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
        end
        nxt_awready = !nxt_aw_have && !nxt_bvalid;
        nxt_wready  = !nxt_w_have && !nxt_bvalid;
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            awaddr_ff     <= 8'h00;
            aw_have_ff    <= 1'b0;
            wdata_ff      <= 32'h0000_0000;
            wstrb0_ff     <= 1'b0;
            w_have_ff     <= 1'b0;
            awready_ff    <= 1'b0;
            wready_ff     <= 1'b0;
            bvalid_ff     <= 1'b0;
            bresp_ff      <= 2'h0;
            ctrl_mcken_ff <= `SCRC_CTRL_RST;
        end
        else
        begin
            awaddr_ff     <= nxt_awaddr;
            aw_have_ff    <= nxt_aw_have;
            wdata_ff      <= nxt_wdata;
            wstrb0_ff     <= nxt_wstrb0;
            w_have_ff     <= nxt_w_have;
            awready_ff    <= nxt_awready;
            wready_ff     <= nxt_wready;
            bvalid_ff     <= nxt_bvalid;
            bresp_ff      <= nxt_bresp;
            ctrl_mcken_ff <= nxt_ctrl_mcken;
        end
    end

    assign S_AXI_AWREADY = awready_ff;
    assign S_AXI_WREADY  = wready_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;

    // ========================================
    // axi4-lite read channel
    logic        arready_ff;
    logic        nxt_arready;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0]  rresp_ff;
    logic [1:0]  nxt_rresp;

    // one read at a time, data one cycle after the address
    always_comb
    begin
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        nxt_rvalid  = rvalid_ff && !S_AXI_RREADY;
        if (S_AXI_ARVALID && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = addr_mapped(S_AXI_ARADDR) ? `SCRC_RESP_OKAY : `SCRC_RESP_SLV;
            nxt_rdata  = 32'h0000_0000;
            unique case (S_AXI_ARADDR)
                `SCRC_OFS_STATUS:
                begin
                    nxt_rdata[`SCRC_ST_LOCKED] = locked_ff;
                    nxt_rdata[`SCRC_ST_SYNC]   = mem_sync_ff;
                    nxt_rdata[`SCRC_ST_PRSV]   = locked_ff && !plat_en_ff;
                    nxt_rdata[`SCRC_ST_CRSV]   = locked_ff && !core0_en_ff;
                end
                `SCRC_OFS_PLAT:
                    nxt_rdata[11:0] = {plat_mult_ff, 5'h00, strap_ff[2:0]};
                `SCRC_OFS_CORE0:
                    nxt_rdata[10:0] = {core0_half_ff, 5'h00, strap_ff[5:3]};
                `SCRC_OFS_CORE1:
                    nxt_rdata[2:0] = strap_ff[8:6];
                `SCRC_OFS_MEM:
                    nxt_rdata[8:0] = {!mem_sync_ff, 5'h00, strap_ff[11:9]};
                `SCRC_OFS_CTRL:
                    nxt_rdata[`SCRC_CTRL_MCKEN] = ctrl_mcken_ff;
                default:
                    nxt_rdata = 32'h0000_0000;
            endcase
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= 2'h0;
        end
        else
        begin
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign S_AXI_ARREADY = arready_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RDATA   = rdata_ff;
    assign S_AXI_RRESP   = rresp_ff;

    // ========================================
    // assertions
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence seq_mck_hi_lo;
        MEM_CLK_P[0] ##1 !MEM_CLK_P[0];
    endsequence

    a_plat_ratio_12: assert property (CFG_LOCKED && strap_ff[2:0] == 3'h5
        |-> PLAT_PLL_MULT == 4'hC && PLAT_PLL_EN)
        else $error("platform code 101 not 12");
    a_plat_reserved: assert property (CFG_LOCKED && strap_ff[2:1] == 2'h3
        |-> !PLAT_PLL_EN && PLAT_PLL_MULT == 4'h0)
        else $error("reserved platform code enabled");
    a_core0_ratio: assert property (CFG_LOCKED && strap_ff[5:3] == 3'h3
        |-> CORE0_PLL_HALF_MULT == 3'h3 && CORE0_PLL_EN)
        else $error("core0 code 011 not 3:2");
    a_core0_reserved: assert property (CFG_LOCKED && strap_ff[5:3] < 3'h3
        |-> !CORE0_PLL_EN)
        else $error("reserved core0 code enabled");
    a_core1_own_strap: assert property ($rose(CFG_LOCKED)
        |-> CORE1_RATIO_CODE == $past(sync3_ff[8:6]))
        else $error("core1 code not from its straps");
    a_mem_sync_sel: assert property ($rose(CFG_LOCKED) && $past(sync3_ff[11:9]) == 3'h7
        |-> MEM_CLK_DIV2_SEL && !MEM_PLL_EN)
        else $error("strap 111 did not select sync");
    a_mem_async_ref: assert property (CFG_LOCKED && !MEM_CLK_DIV2_SEL
        |-> MEM_PLL_REF_SEL && MEM_PLL_EN)
        else $error("async mode without memory pll");
    a_mck_half_rate: assert property (CFG_LOCKED && ctrl_mcken_ff && MEM_CLK_P[0]
        |-> seq_mck_hi_lo and (MEM_CLK_N == ~MEM_CLK_P))
        else $error("memory clock not toggling");
    a_straps_held: assert property (CFG_LOCKED
        |=> (CFG_LOCKED && $stable(strap_ff)) [*2])
        else $error("latched straps changed");

endmodule

`default_nettype wire

//--- dv/scrc_board.sv
`timescale 1ns/100ps
`default_nettype none
// ========================================
// board straps: resistor levels at the strap pins, inverted while reuse is high
module scrc_board (
    // codes chosen for the board
    input  wire logic [2:0] plat_code,
    input  wire logic [2:0] core0_code,
    input  wire logic [2:0] core1_code,
    input  wire logic [2:0] mem_code,
    // high once the shared pins carry other traffic
    input  wire logic       reuse,
    // strap pins
    output logic [2:0]      plat_pins,
    output logic            c0_msb,
    output logic            c0_mid,
    output logic            c0_lsb,
    output logic [2:0]      core1_pins,
    output logic [2:0]      mem_pins
);
    logic [2:0] traffic; // pattern the pins show after reuse
    // every strap is driven to a level, none floats
    always_comb
    begin
        traffic                  = reuse ? 3'h7 : 3'h0;
        plat_pins                = plat_code ^ traffic;
        {c0_msb, c0_mid, c0_lsb} = core0_code ^ traffic;
        core1_pins               = core1_code ^ traffic;
        // mode and ratio choice rests with the board
        mem_pins                 = mem_code ^ traffic;
    end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/100ps
`include "scrc_map.svh"
`default_nettype none
// ========================================
// bench for the strap clock ratio block
module tb_top;
    localparam logic [3:0] MULT_T [8] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC, 4'h0, 4'h0};
    localparam logic [2:0] HALF_T [8] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic        ref_clk, rstn, reuse;       // clock, reset, pin reuse
    logic [2:0]  pc, c0c, c1c, mc;           // board codes
    wire  [2:0]  pp, c1p, mp;                // strap pins
    wire         c0h, c0m, c0l;              // core0 strap pins
    wire  [3:0]  plat_mult;                  // decoded outputs
    wire  [2:0]  c0_half, c1_code;
    wire         plat_en, c0_en, mem_en, ref_sel, div2, locked;
    wire  [5:0]  mem_p, mem_n;               // memory clocks
    logic [7:0]  awaddr, araddr;             // axi master side
    logic [31:0] wdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          errors, checked, i, n;
    logic [31:0] d;                          // read data
    logic [1:0]  r;                          // response
    logic [2:0]  code;
    logic        s;                          // synchronous mode expected
    scrc_board board (.plat_code(pc), .core0_code(c0c), .core1_code(c1c), .mem_code(mc),
        .reuse(reuse), .plat_pins(pp), .c0_msb(c0h), .c0_mid(c0m), .c0_lsb(c0l),
        .core1_pins(c1p), .mem_pins(mp));
    scrc_top #(.SETTLE_CYC(5), .NUM_MCK(6)) dut (.REF_CLK(ref_clk), .RSTN(rstn),
        .PLATFORM_RATIO_STRAPS(pp), .CORE0_RATIO_STRAP_MSB(c0h), .CORE0_RATIO_STRAP_MID(c0m),
        .CORE0_RATIO_STRAP_LSB(c0l), .CORE1_RATIO_STRAPS(c1p), .MEM_PLL_CFG_STRAPS(mp),
        .PLAT_PLL_MULT(plat_mult), .PLAT_PLL_EN(plat_en), .CORE0_PLL_HALF_MULT(c0_half),
        .CORE0_PLL_EN(c0_en), .CORE1_RATIO_CODE(c1_code), .MEM_PLL_EN(mem_en),
        .MEM_PLL_REF_SEL(ref_sel), .MEM_CLK_DIV2_SEL(div2), .CFG_LOCKED(locked),
        .MEM_CLK_P(mem_p), .MEM_CLK_N(mem_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    // ========================================
    // helpers
    function automatic logic [2:0] mem_of(input logic [2:0] c);
        return c[0] ? `SCRC_MEM_SYNC : c; // odd codes pick synchronous mode
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // write: address and data offered together, each released when taken
    task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic aw, w, ta, tw;
        @(posedge ref_clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        // no cycle count assumed: only the watchdog ends a wait
        while (!(aw && w))
        begin
            @(negedge ref_clk);
            ta = awvalid && (awready === 1'b1);
            tw = wvalid && (wready === 1'b1);
            @(posedge ref_clk);
            if (ta)
            begin
                awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (tw)
            begin
                wvalid <= 1'b0;
                w = 1'b1;
            end
        end
        while (bvalid !== 1'b1)
            @(negedge ref_clk);
        // response taken at the edge where bready meets bvalid
        @(posedge ref_clk);
        resp = bresp;
        bready <= 1'b0;
    endtask
    // read: hold the address until taken, then hold rready until data
    task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        @(negedge ref_clk);
        while (arready !== 1'b1)
            @(negedge ref_clk);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(negedge ref_clk);
        // data taken at the edge where rready meets rvalid
        @(posedge ref_clk);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // decoded pll controls for one strap code
    task chk_cfg(input logic [2:0] c);
        s = (mem_of(c) === `SCRC_MEM_SYNC);
        chk({28'h0, plat_mult}, {28'h0, MULT_T[c]});
        chk({31'h0, plat_en}, {31'h0, c < 3'h6});
        chk({29'h0, c0_half}, {29'h0, HALF_T[c]});
        chk({31'h0, c0_en}, {31'h0, c >= 3'h3});
        chk({29'h0, c1_code}, {29'h0, ~c});
        chk({29'h0, mem_en, ref_sel, div2}, {29'h0, !s, !s, s});
    endtask
    // memory clock toggles every cycle, n is the complement
    task chk_mck;
        logic [5:0] p;
        @(negedge ref_clk);
        p = mem_p;
        @(negedge ref_clk);
        chk({26'h0, mem_p}, {26'h0, ~p});
        chk({26'h0, mem_n}, {26'h0, ~mem_p});
    endtask
    // ========================================
    // clock and watchdog
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (8000) @(posedge ref_clk);
        errors++;
        finish_test;
    end
    // ========================================
    // main sequence: every platform and core strap code, memory codes 000/010/100/110/111, then register bus corners
    initial
    begin
        errors = 0; checked = 0; rstn = 1'b0; reuse = 1'b0;
        pc = 3'h0; c0c = 3'h0; c1c = 3'h7; mc = 3'h0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        repeat (20) @(posedge ref_clk);
        for (i = 0; i < 8; i++)
        begin
            code = 3'(i);
            @(posedge ref_clk);
            rstn <= 1'b0; reuse <= 1'b0;
            pc <= code; c0c <= code; c1c <= ~code; mc <= mem_of(code);
            repeat (3) @(posedge ref_clk);
            rstn <= 1'b1;
            n = 0;
            do begin @(negedge ref_clk); n++; end while (locked !== 1'b1 && n < 50);
            chk({31'h0, locked}, 32'h1);
            chk_cfg(code);
            axi_rd(`SCRC_OFS_PLAT, d, r);
            chk(d, {20'h0, MULT_T[code], 5'h0, code});
            axi_rd(`SCRC_OFS_CORE0, d, r);
            chk({r, d[29:0]}, {`SCRC_RESP_OKAY, 19'h0, HALF_T[code], 5'h0, code});
            axi_rd(`SCRC_OFS_STATUS, d, r);
            chk(d, {28'h0, code < 3'h3, code >= 3'h6, s, 1'b1});
            axi_rd(`SCRC_OFS_CORE1, d, r);
            chk(d, {29'h0, ~code});
            axi_rd(`SCRC_OFS_MEM, d, r);
            chk(d, {23'h0, !s, 5'h0, mem_of(code)});
            reuse <= 1'b1;
            repeat (10) @(posedge ref_clk);
            chk_cfg(code);
            chk_mck;
        end
        axi_rd(`SCRC_OFS_CTRL, d, r);
        chk(d, 32'h1);
        axi_wr(`SCRC_OFS_CTRL, 32'h0, r);
        chk({30'h0, r}, {30'h0, `SCRC_RESP_OKAY});
        repeat (2) @(negedge ref_clk);
        chk({20'h0, mem_p, mem_n}, 32'h0000003F);
        axi_wr(`SCRC_OFS_CTRL, 32'h1, r);
        chk_mck;
        axi_wr(`SCRC_OFS_STATUS, 32'hFFFFFFFF, r);
        chk({30'h0, r}, {30'h0, `SCRC_RESP_OKAY});
        axi_rd(`SCRC_OFS_STATUS, d, r);
        chk(d, 32'h00000007);
        axi_rd(8'h40, d, r);
        chk({r, d[29:0]}, {`SCRC_RESP_SLV, 30'h0});
        axi_rd(8'h05, d, r);
        chk({30'h0, r}, {30'h0, `SCRC_RESP_SLV});
        axi_wr(8'h40, 32'h1, r);
        chk({30'h0, r}, {30'h0, `SCRC_RESP_SLV});
        finish_test;
    end
endmodule
`default_nettype wire
